/* src/isr_pkg.sv */
// shared constants for the interleaved sram ready/enable logic
// assumes a single 20 MHz system clock and a synchronous reset
package isr_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int WE_MIN_PULSE_NS = 35;
  localparam int WE_MIN_CYCLES   =
    (WE_MIN_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // ------------------------------------------------------------
  // counter layout
  // ------------------------------------------------------------
  localparam int CNT_WIDTH  = 8;
  localparam int UPPER_BITS = 7;
  localparam int LOWER_BITS = 4;
  localparam logic [CNT_WIDTH-1:0] CNT_RESET = 8'h00;
  localparam logic STRAP_EVEN = 1'b1;
  localparam logic STRAP_ODD  = 1'b0;
endpackage

/* src/isr_bank_counter.sv */
// one bank address counter, shared design for both banks
// assumes load and count come from the controller on the same clock
`timescale 1ns/1ps
module isr_bank_counter
  import isr_pkg::*;
(
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // strap and control
  input  wire logic                 even_strap_i,
  input  wire logic                 address_capture_i,
  input  wire logic                 advance_enable_i,
  input  wire logic                 bank_phase_input_i,
  input  wire logic [CNT_WIDTH-1:0] load_value_i,
  // count
  output logic      [CNT_WIDTH-1:0] count_o,
  output logic                      carry_o
);
  import isr_pkg::*;

  logic [LOWER_BITS-1:0] lower;
  logic [CNT_WIDTH-LOWER_BITS-1:0] upper;
  logic                  upper_step;
  logic                  lower_full;

  assign upper_step = advance_enable_i & lower[0];
  assign lower_full = &lower[LOWER_BITS-1:1];
  assign carry_o    = upper_step & lower_full;
  assign count_o    = {upper, lower};

  // ------------------------------------------------------------
  // lower half
  // ------------------------------------------------------------
  // strap picks lsb treatment
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lower <= CNT_RESET[LOWER_BITS-1:0];
    end else if (address_capture_i) begin
      // odd lsb forced to zero on load, so one count enable serves both
      lower <= {load_value_i[LOWER_BITS-1:1],
                (even_strap_i == STRAP_EVEN) ? load_value_i[0] : 1'b0};
    end else if (advance_enable_i) begin
      if (upper_step) begin
        lower[LOWER_BITS-1:1] <= lower[LOWER_BITS-1:1] + 3'h1;
      end
      lower[0] <= (even_strap_i == STRAP_EVEN) ? ~lower[0] : bank_phase_input_i;
    end
  end

  // ------------------------------------------------------------
  // upper half
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      upper <= CNT_RESET[CNT_WIDTH-1:LOWER_BITS];
    end else if (address_capture_i) begin
      upper <= load_value_i[CNT_WIDTH-1:LOWER_BITS];
    end else if (carry_o) begin
      upper <= upper + 4'h1;
    end
  end

  // upper moves only with lsb set
  a_upper_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    (!address_capture_i && !upper_step) |=> $stable(count_o[CNT_WIDTH-1:1]))
    else $error("upper counter bits moved without lsb and enable");
endmodule

/* src/isr_ready_enable.sv */
// ready, output enable, write enable and chip enable for two-bank sram
// assumes decode and exit conditions come from the surrounding controller
//
// Notes on behaviour
// - instr ready two cycles after request
// - burst ready when request and ack held
// - no instr ready during its load cycle
// - instr ready is combinational
// - even lsb picks instr bank drive
// - data ready early on writes
// - data bank drives only on reads
// - registered write enable whole second cycle
// - write enable needs prior data ready
// - odd bank takes even lsb as phase input
// - write data capture by phase only
// - registered chip enable held until load
// - deselect only on a load without block hit
// - split counters pass carry upward
// - strap selects even or odd counter
// - upper bits step when lsb set
// - counter lsbs differ after each count step
// - instr load is one-cycle pulse
// - counters advance on count enable
// - even lsb high means even second half
// - data access blocks instr acknowledge
`timescale 1ns/1ps
module isr_ready_enable
  import isr_pkg::*;
(
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // processor requests
  input  wire logic                 instr_request_i,
  input  wire logic                 data_request_i,
  input  wire logic                 instr_burst_request_i,
  input  wire logic                 data_burst_request_i,
  input  wire logic                 bus_invalid_i,
  input  wire logic                 read_not_write_i,
  input  wire logic [CNT_WIDTH-1:0] address_i,
  // decode and exits
  input  wire logic                 instr_block_hit_i,
  input  wire logic                 data_block_hit_i,
  input  wire logic                 instr_exit_i,
  input  wire logic                 data_exit_i,
  // acknowledges and ready
  output logic                      instr_burst_ack_o,
  output logic                      data_burst_ack_o,
  output logic                      instr_ready_out_o,
  output logic                      data_ready_out_o,
  // bank enables
  output logic                      even_bank_instr_drive_o,
  output logic                      odd_bank_instr_drive_o,
  output logic                      even_bank_data_drive_o,
  output logic                      odd_bank_data_drive_o,
  output logic                      even_write_en_o,
  output logic                      odd_write_en_o,
  output logic                      even_write_data_capture_en_o,
  output logic                      odd_write_data_capture_en_o,
  output logic                      chip_enable_o,
  // bank addresses
  output logic [UPPER_BITS-1:0]     even_bank_address_o,
  output logic [UPPER_BITS-1:0]     odd_bank_address_o
);
  import isr_pkg::*;

  logic instr_load_pulse;
  logic instr_load_pulse_dly;
  logic data_load_pulse;
  logic data_load_pulse_dly;
  logic instr_burst_ack_dly;
  logic data_burst_ack_dly;
  logic instr_burst_request_dly;
  logic data_burst_request_dly;
  logic bus_invalid_dly;
  logic address_capture;
  logic advance_enable;
  logic block_selected;
  logic instr_burst_go;
  logic data_burst_go;
  logic even_counter_phase_bit;
  logic odd_counter_lsb;
  logic [CNT_WIDTH-1:0] even_count;
  logic [CNT_WIDTH-1:0] odd_count;
  logic next_instr_ack;
  logic next_data_ack;

  // ------------------------------------------------------------
  // acknowledge state
  // ------------------------------------------------------------
  // a held acknowledge blocks the other access
  assign next_instr_ack = (instr_block_hit_i & ~data_burst_ack_o & ~bus_invalid_i)
                        | (~instr_exit_i & instr_burst_ack_o);
  assign next_data_ack  = (data_block_hit_i & ~instr_burst_ack_o & ~bus_invalid_i)
                        | (~data_exit_i & data_burst_ack_o);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      instr_burst_ack_o <= 1'b0;
      data_burst_ack_o  <= 1'b0;
    end else begin
      instr_burst_ack_o <= next_instr_ack;
      data_burst_ack_o  <= next_data_ack;
    end
  end

  // ------------------------------------------------------------
  // load pulses and delayed copies
  // ------------------------------------------------------------
  // one-cycle qualified load pulse
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      instr_load_pulse     <= 1'b0;
      instr_load_pulse_dly <= 1'b0;
      data_load_pulse      <= 1'b0;
      data_load_pulse_dly  <= 1'b0;
    end else begin
      instr_load_pulse     <= ~data_burst_ack_o & instr_block_hit_i & ~instr_load_pulse
                            & ~instr_load_pulse_dly & ~bus_invalid_i;
      instr_load_pulse_dly <= instr_load_pulse;
      data_load_pulse      <= ~instr_burst_ack_o & data_block_hit_i & ~data_load_pulse
                            & ~data_load_pulse_dly & ~bus_invalid_dly;
      data_load_pulse_dly  <= data_load_pulse;
    end
  end

  // late burst requests can only be used registered
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      instr_burst_ack_dly     <= 1'b0;
      data_burst_ack_dly      <= 1'b0;
      instr_burst_request_dly <= 1'b0;
      data_burst_request_dly  <= 1'b0;
      bus_invalid_dly         <= 1'b0;
    end else begin
      instr_burst_ack_dly     <= instr_burst_ack_o;
      data_burst_ack_dly      <= data_burst_ack_o;
      instr_burst_request_dly <= instr_burst_request_i;
      data_burst_request_dly  <= data_burst_request_i;
      bus_invalid_dly         <= bus_invalid_i;
    end
  end

  // ------------------------------------------------------------
  // load and count
  // ------------------------------------------------------------
  assign address_capture = (instr_request_i & ~data_burst_ack_o & ~instr_load_pulse
                            & ~instr_load_pulse_dly)
                         | (data_request_i & ~instr_burst_ack_o & ~data_load_pulse
                            & ~data_load_pulse_dly);
  assign advance_enable  = instr_load_pulse | data_load_pulse
                         | (~bus_invalid_dly & instr_burst_request_dly & instr_burst_ack_o)
                         | (~bus_invalid_dly & data_burst_request_dly & data_burst_ack_o);
  assign block_selected  = instr_block_hit_i | data_block_hit_i;

  // ------------------------------------------------------------
  // ready and bank drives
  // ------------------------------------------------------------
  // continued burst ready term
  assign instr_burst_go = ~bus_invalid_dly & instr_burst_request_dly & instr_burst_ack_dly;
  assign data_burst_go  = ~bus_invalid_dly & data_burst_request_dly & data_burst_ack_dly;
  assign instr_ready_out_o = instr_load_pulse_dly | (instr_burst_go & ~instr_load_pulse);
  assign data_ready_out_o  = (~read_not_write_i & data_load_pulse)
                           | (read_not_write_i & data_load_pulse_dly)
                           | (data_burst_go & ~data_load_pulse);

  // even lsb marks even second half
  assign even_counter_phase_bit = even_count[0];
  assign odd_counter_lsb        = odd_count[0];
  assign even_bank_instr_drive_o = instr_ready_out_o & even_counter_phase_bit;
  assign odd_bank_instr_drive_o  = instr_ready_out_o & ~even_counter_phase_bit;
  assign even_bank_data_drive_o  = read_not_write_i & even_counter_phase_bit
                                 & (data_load_pulse_dly | (data_burst_go & ~data_load_pulse));
  assign odd_bank_data_drive_o   = read_not_write_i & ~even_counter_phase_bit
                                 & (data_load_pulse_dly | (data_burst_go & ~data_load_pulse));

  assign even_write_data_capture_en_o = even_counter_phase_bit;
  assign odd_write_data_capture_en_o  = ~even_counter_phase_bit;

  // ------------------------------------------------------------
  // write enables and chip enable
  // ------------------------------------------------------------
  // registered write enable, writes only
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      even_write_en_o <= 1'b0;
      odd_write_en_o  <= 1'b0;
    end else begin
      even_write_en_o <= data_ready_out_o & ~read_not_write_i & even_counter_phase_bit;
      odd_write_en_o  <= data_ready_out_o & ~read_not_write_i & ~even_counter_phase_bit;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      chip_enable_o <= 1'b0;
    end else if (address_capture) begin
      chip_enable_o <= block_selected;
    end
  end

  // ------------------------------------------------------------
  // bank counters
  // ------------------------------------------------------------
  // even strap high, odd strap low
  isr_bank_counter u_even_counter (
    .clock_i            (clock_i),
    .rst_i              (rst_i),
    .even_strap_i       (STRAP_EVEN),
    .address_capture_i  (address_capture),
    .advance_enable_i   (advance_enable),
    .bank_phase_input_i (1'b0),
    .load_value_i       (address_i),
    .count_o            (even_count),
    .carry_o            ()
  );

  isr_bank_counter u_odd_counter (
    .clock_i            (clock_i),
    .rst_i              (rst_i),
    .even_strap_i       (STRAP_ODD),
    .address_capture_i  (address_capture),
    .advance_enable_i   (advance_enable),
    .bank_phase_input_i (even_counter_phase_bit),
    .load_value_i       (address_i),
    .count_o            (odd_count),
    .carry_o            ()
  );

  assign even_bank_address_o = even_count[CNT_WIDTH-1:1];
  assign odd_bank_address_o  = odd_count[CNT_WIDTH-1:1];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_instr_ready_delay: assert property (@(posedge clock_i) disable iff (rst_i)
    instr_load_pulse |=> instr_ready_out_o)
    else $error("instr ready missing after load");

  a_burst_ready_cause: assert property (@(posedge clock_i) disable iff (rst_i)
    (instr_burst_request_i && instr_burst_ack_o && !bus_invalid_i)
      ##1 !instr_load_pulse |-> instr_ready_out_o)
    else $error("burst ready missing");

  a_load_masks_ready: assert property (@(posedge clock_i) disable iff (rst_i)
    (instr_load_pulse && !instr_load_pulse_dly) |-> !instr_ready_out_o)
    else $error("instr ready during load cycle");

  a_instr_bank_pick: assert property (@(posedge clock_i) disable iff (rst_i)
    instr_ready_out_o |-> (even_bank_instr_drive_o == even_count[0])
                        && (odd_bank_instr_drive_o != even_count[0]))
    else $error("wrong instr bank driven");

  a_write_early_ready: assert property (@(posedge clock_i) disable iff (rst_i)
    (data_load_pulse && !read_not_write_i) |-> data_ready_out_o)
    else $error("write ready not early");

  a_data_read_only: assert property (@(posedge clock_i) disable iff (rst_i)
    !read_not_write_i |-> !(even_bank_data_drive_o || odd_bank_data_drive_o))
    else $error("data bank driven on write");

  a_we_needs_ready: assert property (@(posedge clock_i) disable iff (rst_i)
    (even_write_en_o || odd_write_en_o) |-> $past(data_ready_out_o))
    else $error("write enable without prior ready");

  a_load_one_cycle: assert property (@(posedge clock_i) disable iff (rst_i)
    instr_load_pulse |=> !instr_load_pulse ##0 instr_load_pulse_dly)
    else $error("instr load not a single pulse");

  a_lsb_differ: assert property (@(posedge clock_i) disable iff (rst_i)
    (advance_enable && !address_capture) ##1 (advance_enable && !address_capture)
      |=> even_count[0] != odd_counter_lsb)
    else $error("counter lsbs equal during burst");

  a_data_priority: assert property (@(posedge clock_i) disable iff (rst_i)
    (data_burst_ack_o && !instr_burst_ack_o) |=> !instr_burst_ack_o)
    else $error("instr ack rose during data access");

  a_ce_holds: assert property (@(posedge clock_i) disable iff (rst_i)
    !address_capture |=> $stable(chip_enable_o))
    else $error("chip enable changed without load");

  a_reset_clears: assert property (@(posedge clock_i) rst_i |=>
    !(instr_burst_ack_o || data_burst_ack_o || even_write_en_o || odd_write_en_o
      || chip_enable_o))
    else $error("registered outputs not cleared by reset");

  a_load_needs_hit: assert property (@(posedge clock_i) disable iff (rst_i)
    instr_load_pulse |-> $past(instr_block_hit_i && !bus_invalid_i))
    else $error("instr load without valid hit");

  a_count_step: assert property (@(posedge clock_i) disable iff (rst_i)
    (advance_enable && !address_capture) |=> (even_count[0] != $past(even_count[0])))
    else $error("counter did not advance on count enable");

  a_invalid_no_ready: assert property (@(posedge clock_i) disable iff (rst_i)
    (bus_invalid_dly && !instr_load_pulse_dly) |-> !instr_ready_out_o)
    else $error("instr ready after invalid bus");

  a_read_ready_late: assert property (@(posedge clock_i) disable iff (rst_i)
    (data_load_pulse && read_not_write_i) |-> !data_ready_out_o)
    else $error("read ready in load cycle");

  a_data_bank_pick: assert property (@(posedge clock_i) disable iff (rst_i)
    (data_ready_out_o && read_not_write_i)
      |-> (even_bank_data_drive_o == even_counter_phase_bit)
       && (odd_bank_data_drive_o != even_counter_phase_bit))
    else $error("wrong data bank driven");

  a_we_writes_only: assert property (@(posedge clock_i) disable iff (rst_i)
    (even_write_en_o || odd_write_en_o) |-> $past(!read_not_write_i))
    else $error("write enable after a read");

  a_we_one_bank: assert property (@(posedge clock_i) disable iff (rst_i)
    !(even_write_en_o && odd_write_en_o))
    else $error("both banks written at once");

  a_odd_we_phase: assert property (@(posedge clock_i) disable iff (rst_i)
    odd_write_en_o |-> $past(!even_counter_phase_bit))
    else $error("odd write enable in even phase");

  a_ce_loads_hit: assert property (@(posedge clock_i) disable iff (rst_i)
    address_capture |=> (chip_enable_o == $past(block_selected)))
    else $error("chip enable did not follow block hit");
endmodule

/* bench/isr_cpu_model.sv */
// processor side model: turns bench commands into bus requests
// assumes commands change right after a rising edge
`timescale 1ns/1ps
module isr_cpu_model
  import isr_pkg::*;
(
  // commands
  input  wire logic                 go_i,
  input  wire logic                 instr_i,
  input  wire logic                 read_i,
  input  wire logic                 hit_i,
  input  wire logic                 burst_i,
  input  wire logic                 inv_i,
  input  wire logic                 exit_i,
  input  wire logic [CNT_WIDTH-1:0] addr_i,
  // bus
  output logic                      instr_request_o,
  output logic                      data_request_o,
  output logic                      instr_hit_o,
  output logic                      data_hit_o,
  output logic                      instr_burst_o,
  output logic                      data_burst_o,
  output logic                      bus_invalid_o,
  output logic                      read_not_write_o,
  output logic [CNT_WIDTH-1:0]      address_o,
  output logic                      instr_exit_o,
  output logic                      data_exit_o
);
  // requests last one cycle; the address bus is released otherwise
  assign instr_request_o  = go_i & instr_i;
  assign data_request_o   = go_i & ~instr_i;
  assign instr_hit_o      = go_i & instr_i & hit_i;
  assign data_hit_o       = go_i & ~instr_i & hit_i;
  assign instr_burst_o    = burst_i & instr_i;
  assign data_burst_o     = burst_i & ~instr_i;
  assign bus_invalid_o    = inv_i;
  assign read_not_write_o = read_i;
  // released bus shows the inverse, not a stale copy
  assign address_o        = go_i ? addr_i : ~addr_i;
  assign instr_exit_o     = exit_i & instr_i;
  assign data_exit_o      = exit_i & ~instr_i;
endmodule

/* bench/testbench.sv */
// self-checking bench for the ready and enable logic
// assumes the processor model sits between bench and design
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t %s", $time, m); end end
module testbench;
  import isr_pkg::*;
  logic clock_i, rst_i, go, ins, rd, hit, bur, inv, ext;
  logic [CNT_WIDTH-1:0] addr, adr;
  logic ir_q, dr_q, br_i, br_d, bi, rw, ie, io, de, dd, we_e, we_o, ce, cap_e, cap_o;
  logic iq, dq, ih, dh, ix, dx, iack, dack;
  logic [UPPER_BITS-1:0] ea, oa;
  logic [7:0] lir, ldr, lie, lio, ldo, lwe, lce, lia;
  int err_total, cmp_count, cyc;
  isr_cpu_model i_isr_cpu_model (.go_i(go), .instr_i(ins), .read_i(rd), .hit_i(hit),
    .burst_i(bur), .inv_i(inv), .exit_i(ext), .addr_i(addr), .instr_request_o(iq),
    .data_request_o(dq), .instr_hit_o(ih), .data_hit_o(dh), .instr_burst_o(br_i),
    .data_burst_o(br_d), .bus_invalid_o(bi), .read_not_write_o(rw), .address_o(adr),
    .instr_exit_o(ix), .data_exit_o(dx));
  isr_ready_enable i_isr_ready_enable (.clock_i(clock_i), .rst_i(rst_i),
    .instr_request_i(iq), .data_request_i(dq), .instr_burst_request_i(br_i),
    .data_burst_request_i(br_d), .bus_invalid_i(bi), .read_not_write_i(rw),
    .address_i(adr), .instr_block_hit_i(ih), .data_block_hit_i(dh),
    .instr_exit_i(ix), .data_exit_i(dx), .instr_burst_ack_o(iack),
    .data_burst_ack_o(dack), .instr_ready_out_o(ir_q), .data_ready_out_o(dr_q),
    .even_bank_instr_drive_o(ie), .odd_bank_instr_drive_o(io),
    .even_bank_data_drive_o(de), .odd_bank_data_drive_o(dd), .even_write_en_o(we_e),
    .odd_write_en_o(we_o), .even_write_data_capture_en_o(cap_e),
    .odd_write_data_capture_en_o(cap_o), .chip_enable_o(ce),
    .even_bank_address_o(ea), .odd_bank_address_o(oa));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // -----------------------------------------------------------
  // verdict and hang guard
  // -----------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  // -----------------------------------------------------------
  // shared drivers: start an access, log n cycles, end one
  // -----------------------------------------------------------
  task automatic start(input logic i, r, h, b, v, input logic [7:0] a);
    @(posedge clock_i);
    go <= 1'b1; ins <= i; rd <= r; hit <= h; bur <= b; inv <= v; addr <= a;
  endtask
  task automatic run(input int n, input int bend, input int vat);
    {lir, ldr, lie, lio, ldo, lwe, lce, lia} = '0;
    for (int k = 0; k < n; k++) begin
      @(negedge clock_i);
      lir[k] = ir_q; ldr[k] = dr_q; lie[k] = ie; lio[k] = io;
      ldo[k] = de | dd; lwe[k] = we_e | we_o; lce[k] = ce; lia[k] = iack;
      @(posedge clock_i);
      go <= 1'b0;
      if (k + 1 == bend) bur <= 1'b0;
      inv <= (k + 1 == vat);
    end
  endtask
  task automatic finish_access(input logic i);
    @(posedge clock_i);
    ins <= i; ext <= 1'b1;
    @(posedge clock_i);
    ext <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_reset();
    @(negedge clock_i);
    `CHK({iack, dack, we_e, we_o, ce, ir_q, dr_q}, 7'h00, "reset outputs")
    `CHK({cap_e, cap_o}, 2'h1, "reset capture enables")
    $display("test reset done");
  endtask
  task automatic t_single();
    start(1, 1, 1, 0, 0, 8'h10); run(5, 0, 0);
    `CHK(lir, 8'h04, "instr single ready")
    `CHK({lie, lio}, 16'h0400, "instr even bank")
    `CHK(lce[1], 1'b1, "chip enable on")
    @(negedge clock_i);
    // even start: no upper step yet
    `CHK({ea, oa}, 14'h0408, "even start addresses")
    `CHK({cap_e, cap_o}, 2'h2, "capture follows phase")
    finish_access(1);
    start(1, 1, 1, 0, 0, 8'h11); run(5, 0, 0);
    `CHK({lie, lio}, 16'h0004, "instr odd bank")
    @(negedge clock_i);
    // odd start: even bank one word ahead
    `CHK({ea, oa}, 14'h0488, "odd start addresses")
    finish_access(1);
    $display("test single fetch done");
  endtask
  task automatic t_data();
    start(0, 1, 1, 0, 0, 8'h10); run(5, 0, 0);
    `CHK({ldr, ldo, lwe}, 24'h040400, "data read")
    finish_access(0);
    start(0, 0, 1, 0, 0, 8'h10); run(5, 0, 0);
    `CHK({ldr, ldo, lwe}, 24'h020004, "data write")
    finish_access(0);
    $display("test data done");
  endtask
  task automatic t_burst();
    start(1, 1, 1, 1, 0, 8'h20); run(7, 4, 0);
    `CHK({lir, lie, lio}, 24'h1c1408, "instr burst")
    @(negedge clock_i);
    `CHK({ea, oa}, 14'h0911, "burst end addresses")
    // new access right after suspended burst
    start(1, 1, 1, 1, 0, 8'h20); run(5, 3, 0);
    `CHK(lir, 8'h0c, "no ready in load cycle")
    finish_access(1);
    start(1, 1, 1, 1, 0, 8'h20); run(7, 4, 3);
    `CHK(lir, 8'h0c, "burst with invalid bus")
    finish_access(1);
    $display("test burst done");
  endtask
  task automatic t_refuse();
    start(1, 1, 1, 0, 1, 8'h10); run(5, 0, 1);
    `CHK({lir, lia}, 16'h0000, "invalid request refused")
    start(0, 0, 1, 0, 0, 8'h10); run(3, 0, 0);
    start(1, 1, 1, 0, 0, 8'h10); run(5, 0, 0);
    `CHK({lir, lia}, 16'h0000, "data priority")
    @(negedge clock_i);
    `CHK(dack, 1'b1, "data ack held")
    finish_access(0);
    start(1, 1, 0, 0, 0, 8'h10); run(4, 0, 0);
    `CHK(lce & 8'h0e, 8'h00, "chip enable off")
    $display("test refuse done");
  endtask
  initial begin
    {go, ins, rd, hit, bur, inv, ext} = '0;
    addr = 8'h00;
    rst_i = 1'b1;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_single();
    t_data();
    t_burst();
    t_refuse();
    give_verdict();
  end
endmodule
